// >>> pkg/vof_pkg.sv
/*
 Constants, types and carriers shared by the video output formatter.
 Assumes a 40 MHz core clock and 8-bit YCrCb samples in offset-binary form.
*/
package vof_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map and reset values
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam int          CTRL_W      = 12;
   localparam int          STATUS_W    = 5;
   localparam logic [11:0] CTRL_RESET  = 12'h200;  // Only code limiting on

   ////////////////////////////////////////////////////////////////////////////////
   // Code words and levels
   localparam logic [7:0] HDR_ONES    = 8'hff;
   localparam logic [7:0] HDR_ZERO    = 8'h00;
   localparam logic [7:0] BLANK_Y     = 8'h10;
   localparam logic [7:0] BLANK_C     = 8'h80;
   localparam logic [7:0] VID_MIN     = 8'h01;
   localparam logic [7:0] VID_MAX     = 8'hfe;
   localparam logic [7:0] ITU_Y_MIN   = 8'h10;
   localparam logic [7:0] ITU_Y_MAX   = 8'hf0;
   localparam logic [7:0] ITU_C_MIN   = 8'h10;
   localparam logic [7:0] ITU_C_MAX   = 8'hf0;
   localparam logic [7:0] CHROMA_SIGN = 8'h80;
   localparam logic [7:0] TP_FLAT_Y   = 8'hb4;
   localparam logic [7:0] TP_BAR_TOP  = 8'heb;
   localparam logic [7:0] TP_C_LOW    = 8'h40;
   localparam logic [7:0] TP_C_HIGH   = 8'hc0;
   localparam logic [2:0] SKEW_FULL   = 3'h4;

   ////////////////////////////////////////////////////////////////////////////////
   // Pipeline geometry: output stage plus two stages of look-ahead and look-back
   localparam int PIPE_DEPTH = 5;
   localparam int OUT_STAGE  = 2;

   typedef enum logic [1:0] {
      TP_YRAMP = 2'b00,
      TP_CRAMP = 2'b01,
      TP_FLAT  = 2'b10,
      TP_BAR   = 2'b11
   } tp_e;

   typedef enum logic [1:0] {
      FMT_16  = 2'b00,
      FMT_8   = 2'b01,
      FMT_411 = 2'b10,
      FMT_656 = 2'b11
   } fmt_e;

   // Control word, bit 0 is the double-clock enable
   typedef struct packed {
      logic [1:0] skew;
      logic       code_limit;
      logic       chroma_signed;
      tp_e        test_sel;
      logic       test_en;
      logic       sync_hiz;
      logic       data_hiz;
      logic       fmt411;
      logic       embedded_header_enable;
      logic       dbl;
   } ctrl_s;

   typedef struct packed {
      logic [7:0] y;
      logic [7:0] cb;
      logic [7:0] cr;
      logic [7:0] helper_y;
      logic       active;
      logic       hsync;
      logic       vsync;
      logic       field;
      logic       vblank;
      logic       line_blank;
      logic       last_line;
      logic       helper_line;
   } video_in_s;

   typedef struct packed {
      logic [7:0] y;
      logic [7:0] cb;
      logic [7:0] cr;
      logic [1:0] idx;
      logic       act;
      logic       hs;
      logic       vs;
      logic       field;
      logic       vblank;
      logic       lblank;
      logic       last;
      logic       helper;
   } pixel_s;

endpackage

// >>> logic/video_output_formatter.sv
/*
 Video output formatter: turns a processed YCrCb pixel stream into the
 16-bit 4:2:2, 8-bit 4:2:2, 4:1:1 or embedded-header 656 output format.
 Assumes the pixel inputs come from logic on clk_i and hold steady between
 output clock edges; the output clock and output-enable pin are asynchronous.
*/
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////
// What this block does
// - 4:1:1 chroma bit pairs spread over four pixels
// - Skew-interpolate chroma onto orthogonal raster for 4:1:1
// - 656 mode muxes words at double rate
// - SAV header just before first active sample
// - EAV header just after last active sample
// - 656 video words clipped to 1..254
// - Blanking words are 0x10 luma, 0x80 chroma
// - Header: ff, 00, 00, flag word
// - Flag word carries T, F, V, H
// - Low flag bits are protection bits
// - Window-blanked lines drop both headers together
// - EAV of last active line has V set
// - Field blanking headers carry V set
// - Double-clock and header enables select format
// - Luma limited 16..240, chroma 128 plus-minus 112
// - Software can tristate data and sync outputs
// - Output-enable pin tristates data outputs
// - Test mode substitutes ramps, flat field, colour bar
// - Helper lines take the main luma path
// - Helper lines bypass comb, appear on luma
// - 4:2:2 chroma alternates Cb, Cr per pair
module video_output_formatter
   import vof_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        pixel_clk_i,
   input  wire logic        pixel_output_enable_n_i,
   input  wire video_in_s   vid_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   output logic      [7:0]  luma_o,
   output logic             luma_oe_o,
   output logic      [7:0]  chroma_o,
   output logic             chroma_oe_o,
   output logic             hsync_o,
   output logic             vsync_o,
   output logic             active_video_marker_o,
   output logic             sync_oe_o,
   output logic             comb_bypass_o
);

   //////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Saturate a code to a window
   function automatic logic [7:0] clip(input logic [7:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
      clip = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // Two-tap interpolation, weight in quarters toward the newer sample
   function automatic logic [7:0] interp(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [1:0] w);
      logic [10:0] acc;
      acc = {3'h0, a} * {8'h00, SKEW_FULL - {1'b0, w}} + {3'h0, b} * {9'h000, w};
      interp = acc[9:2];
   endfunction

   // A line carries headers unless the window blanked it outside field blanking
   function automatic logic hdr_ok(input pixel_s p);
      hdr_ok = !(p.lblank && !p.vblank);
   endfunction

   // Fourth header word with its protection bits
   function automatic logic [7:0] hdr_flag(input pixel_s p, input logic h);
      logic f;
      logic v;
      f = p.field;
      v = p.vblank | (h & p.last);
      hdr_flag = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction

   //////////////////////////////////////////////////////////////////////////////////
   // Declarations
   ctrl_s       ctrl_reg;
   logic        lclk_s1_reg;
   logic        lclk_s2_reg;
   logic        lclk_d_reg;
   logic        oen_s1_reg;
   logic        oen_s2_reg;
   logic        sub_reg;
   logic [9:0]  pix_cnt_reg;
   pixel_s      pipe_reg [0:PIPE_DEPTH-1];
   logic [7:0]  grp_cb_reg;
   logic [7:0]  grp_cr_reg;
   logic [7:0]  luma_reg;
   logic [7:0]  chroma_reg;
   logic        hs_reg;
   logic        vs_reg;
   logic        avo_reg;
   logic        field_reg;
   logic        hdr_word_reg;
   logic        luma_oe_reg;
   logic        chroma_oe_reg;
   logic        sync_oe_reg;
   logic        bypass_reg;
   logic [31:0] rdata_reg;
   logic        hdr3_q;
   logic        vid656_q;
   logic        blank656_q;
   logic        fmt411_q;
   logic        fmt656_q;
   logic        lim_q;

   //////////////////////////////////////////////////////////////////////////////////
   // Output clock and pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lclk_s1_reg <= 1'b0;
         lclk_s2_reg <= 1'b0;
         lclk_d_reg  <= 1'b0;
         oen_s1_reg  <= 1'b1;
         oen_s2_reg  <= 1'b1;
      end else begin
         lclk_s1_reg <= pixel_clk_i;
         lclk_s2_reg <= lclk_s1_reg;
         lclk_d_reg  <= lclk_s2_reg;
         oen_s1_reg  <= pixel_output_enable_n_i;
         oen_s2_reg  <= oen_s1_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Format and slot decode
   fmt_e fmt_w;
   logic slot_evt;
   logic shift_en;
   logic act_rise;

   assign slot_evt = lclk_s2_reg & ~lclk_d_reg;
   // Headers need the double-rate port, so headers without it stay plain 16-bit, or 4:1:1 when fmt411 is set
   assign fmt_w    = (ctrl_reg.dbl && ctrl_reg.embedded_header_enable) ? FMT_656 :
                     ctrl_reg.dbl    ? FMT_8 :
                     ctrl_reg.fmt411 ? FMT_411 : FMT_16;
   // In double-clock modes one pixel spans two word slots
   assign shift_en = slot_evt & (~ctrl_reg.dbl | sub_reg);
   assign act_rise = vid_i.active & ~pipe_reg[0].act;

   //////////////////////////////////////////////////////////////////////////////////
   // Pixel source: helper lines replace comb-filtered luma, then test patterns
   logic [9:0] pcnt_w;
   logic [2:0] bar_w;
   logic [7:0] bar_y_w;
   logic [7:0] src_y_w;
   logic [7:0] tp_y;
   logic [7:0] tp_cb;
   logic [7:0] tp_cr;
   pixel_s     new_pix;

   assign pcnt_w  = act_rise ? 10'h000 : pix_cnt_reg;
   assign bar_w   = pcnt_w[9:7];
   assign bar_y_w = TP_BAR_TOP - ({1'b0, bar_w, 4'h0} + {2'h0, bar_w, 3'h0});
   assign src_y_w = vid_i.helper_line ? vid_i.helper_y : vid_i.y;

   // Ramp and bar patterns are generated from the pixel count of the line; the flat field is a constant level
   always_comb begin
      tp_y  = TP_FLAT_Y;
      tp_cb = BLANK_C;
      tp_cr = BLANK_C;
      case (ctrl_reg.test_sel)
         TP_YRAMP: begin
            tp_y = pcnt_w[7:0];
         end
         TP_CRAMP: begin
            tp_cb = pcnt_w[7:0];
            tp_cr = ~pcnt_w[7:0];
         end
         TP_FLAT: begin
            tp_y = TP_FLAT_Y;
         end
         TP_BAR: begin
            tp_y  = bar_y_w;
            tp_cb = bar_w[0] ? TP_C_HIGH : TP_C_LOW;
            tp_cr = bar_w[1] ? TP_C_HIGH : TP_C_LOW;
         end
         default: begin
            tp_y = TP_FLAT_Y;
         end
      endcase
   end

   // Assemble the next pixel, limiting codes to the studio range when asked
   always_comb begin
      new_pix        = '0;
      new_pix.y      = ctrl_reg.test_en ? tp_y : src_y_w;
      new_pix.cb     = ctrl_reg.test_en ? tp_cb : vid_i.cb;
      new_pix.cr     = ctrl_reg.test_en ? tp_cr : vid_i.cr;
      if (ctrl_reg.code_limit) begin
         new_pix.y  = clip(new_pix.y, ITU_Y_MIN, ITU_Y_MAX);
         new_pix.cb = clip(new_pix.cb, ITU_C_MIN, ITU_C_MAX);
         new_pix.cr = clip(new_pix.cr, ITU_C_MIN, ITU_C_MAX);
      end
      new_pix.idx    = pcnt_w[1:0];  // Pair and group position from line start
      new_pix.act    = vid_i.active;
      new_pix.hs     = vid_i.hsync;
      new_pix.vs     = vid_i.vsync;
      new_pix.field  = vid_i.field;
      new_pix.vblank = vid_i.vblank;
      new_pix.lblank = vid_i.line_blank;
      new_pix.last   = vid_i.last_line;
      new_pix.helper = vid_i.helper_line;
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Pixel pipeline: two stages of look-ahead give room for SAV, two of look-back
   // mark where EAV goes; costs two pixels of latency in every format
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_reg[i] <= '0;
         end
         pix_cnt_reg <= 10'h000;
      end else if (shift_en) begin
         pipe_reg[0] <= new_pix;
         for (int i = 1; i < PIPE_DEPTH; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
         end
         pix_cnt_reg <= vid_i.active ? pcnt_w + 10'h001 : 10'h000;
      end
   end

   // Word slot phase: even slot chroma, odd slot luma
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sub_reg <= 1'b0;
      end else if (slot_evt) begin
         sub_reg <= ctrl_reg.dbl ? ~sub_reg : 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Stage aliases and header decode
   pixel_s     d0;
   pixel_s     d1;
   pixel_s     d2;
   pixel_s     d3;
   pixel_s     d4;
   logic       sav_w;
   logic       eav_w;
   logic [1:0] hidx_w;
   logic [7:0] hdr_w;

   assign d0 = pipe_reg[0];
   assign d1 = pipe_reg[1];
   assign d2 = pipe_reg[OUT_STAGE];
   assign d3 = pipe_reg[3];
   assign d4 = pipe_reg[4];
   // SAV fills the four slots before the first active pixel reaches the output
   assign sav_w  = !d2.act && (d0.act || d1.act) && hdr_ok(d1.act ? d1 : d0);
   // EAV fills the four slots after the last active pixel left the output
   assign eav_w  = !d2.act && (d3.act || d4.act) && hdr_ok(d3.act ? d3 : d4);
   assign hidx_w = sav_w ? {d1.act, sub_reg} : {~d3.act, sub_reg};

   always_comb begin
      case (hidx_w)
         2'b00:   hdr_w = HDR_ONES;
         2'b01:   hdr_w = HDR_ZERO;
         2'b10:   hdr_w = HDR_ZERO;
         2'b11:   hdr_w = sav_w ? hdr_flag(d1, 1'b0) : hdr_flag(d4, 1'b1);
         default: hdr_w = HDR_ZERO;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Chroma paths
   logic [7:0] c422_w;
   logic [7:0] cout_w;
   logic [7:0] gcb_w;
   logic [7:0] gcr_w;
   logic [7:0] cb_sh_w;
   logic [7:0] cr_sh_w;
   logic [7:0] c411_w;
   logic       vis_w;

   // First pixel of a pair carries Cb, second Cr, both co-sited with the pair
   assign c422_w  = d2.idx[0] ? d2.cr : d2.cb;
   assign cout_w  = ctrl_reg.chroma_signed ? (c422_w ^ CHROMA_SIGN) : c422_w;
   // Group chroma is skew-interpolated between the previous and first pixel
   assign gcb_w   = (d2.idx == 2'b00) ? interp(d3.cb, d2.cb, ctrl_reg.skew) : grp_cb_reg;
   assign gcr_w   = (d2.idx == 2'b00) ? interp(d3.cr, d2.cr, ctrl_reg.skew) : grp_cr_reg;
   assign cb_sh_w = gcb_w << {d2.idx, 1'b0};
   assign cr_sh_w = gcr_w << {d2.idx, 1'b0};
   // Each pixel carries two bits of Cb and two of Cr, duplicated on both nibbles
   assign c411_w  = {cb_sh_w[7], cb_sh_w[6], cr_sh_w[7], cr_sh_w[6],
                     cb_sh_w[7], cb_sh_w[6], cr_sh_w[7], cr_sh_w[6]};
   assign vis_w   = d2.act && !d2.vblank && !d2.lblank;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         grp_cb_reg <= BLANK_C;
         grp_cr_reg <= BLANK_C;
      end else if (shift_en && d2.idx == 2'b00) begin
         grp_cb_reg <= gcb_w;
         grp_cr_reg <= gcr_w;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Output word selection per format
   logic [7:0] w656_w;
   logic [7:0] luma_next;
   logic [7:0] chroma_next;
   logic       hdr_emit_w;

   assign hdr_emit_w = sav_w | eav_w;
   assign w656_w = hdr_emit_w ? hdr_w :
                   !vis_w     ? (sub_reg ? BLANK_Y : BLANK_C) :
                   sub_reg    ? clip(d2.y, VID_MIN, VID_MAX) :
                                clip(cout_w, VID_MIN, VID_MAX);

   always_comb begin
      case (fmt_w)
         FMT_656: begin
            luma_next   = w656_w;
            chroma_next = 8'h00;
         end
         FMT_8: begin
            luma_next   = sub_reg ? d2.y : cout_w;
            chroma_next = 8'h00;
         end
         FMT_411: begin
            luma_next   = d2.y;
            chroma_next = c411_w;
         end
         default: begin
            // Limit luma again here: pixels taken before the limit was on may still be in flight
            luma_next   = ctrl_reg.code_limit ? clip(d2.y, ITU_Y_MIN, ITU_Y_MAX) : d2.y;
            chroma_next = cout_w;
         end
      endcase
   end

   // Port registers advance once per output clock word slot
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         luma_reg     <= BLANK_Y;
         chroma_reg   <= BLANK_C;
         hs_reg       <= 1'b0;
         vs_reg       <= 1'b0;
         avo_reg      <= 1'b0;
         field_reg    <= 1'b0;
         hdr_word_reg <= 1'b0;
         bypass_reg   <= 1'b0;
      end else if (slot_evt) begin
         luma_reg     <= luma_next;
         chroma_reg   <= chroma_next;
         hs_reg       <= (fmt_w != FMT_656) & d2.hs;
         vs_reg       <= (fmt_w != FMT_656) & d2.vs;
         avo_reg      <= (fmt_w != FMT_656) & d2.act;
         field_reg    <= d2.field;
         hdr_word_reg <= (fmt_w == FMT_656) & hdr_emit_w;
         bypass_reg   <= new_pix.helper;
      end
   end

   // Enables follow the pin and control bits on every clock, not per slot
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         luma_oe_reg   <= 1'b0;
         chroma_oe_reg <= 1'b0;
         sync_oe_reg   <= 1'b0;
      end else begin
         luma_oe_reg   <= ~ctrl_reg.data_hiz & ~oen_s2_reg;
         chroma_oe_reg <= ~ctrl_reg.data_hiz & ~oen_s2_reg & ~ctrl_reg.dbl;
         sync_oe_reg   <= ~ctrl_reg.sync_hiz;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Register port: control write, read data valid in the following cycle only
   logic [31:0] rd_mux_w;
   logic [STATUS_W-1:0] status_w;

   assign status_w = {d2.act, sub_reg, hdr_word_reg, oen_s2_reg, field_reg};
   assign rd_mux_w = (reg_addr_i == REG_CTRL)   ? {{(32-CTRL_W){1'b0}}, ctrl_reg} :
                     (reg_addr_i == REG_STATUS) ? {{(32-STATUS_W){1'b0}}, status_w} :
                                                  32'h0000_0000;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_reg  <= ctrl_s'(CTRL_RESET);
         rdata_reg <= 32'h0000_0000;
      end else begin
         if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            ctrl_reg <= ctrl_s'(reg_wdata_i[CTRL_W-1:0]);
         end
         rdata_reg <= reg_rd_i ? rd_mux_w : 32'h0000_0000;
      end
   end

   assign reg_rdata_o           = rdata_reg;
   assign luma_o                = luma_reg;
   assign luma_oe_o             = luma_oe_reg;
   assign chroma_o              = chroma_reg;
   assign chroma_oe_o           = chroma_oe_reg;
   assign hsync_o               = hs_reg;
   assign vsync_o               = vs_reg;
   assign active_video_marker_o = avo_reg;
   assign sync_oe_o             = sync_oe_reg;
   assign comb_bypass_o         = bypass_reg;

   //////////////////////////////////////////////////////////////////////////////////
   // Word-kind trackers read only by the checks below
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hdr3_q     <= 1'b0;
         vid656_q   <= 1'b0;
         blank656_q <= 1'b0;
         fmt411_q   <= 1'b0;
         fmt656_q   <= 1'b0;
         lim_q      <= 1'b0;
      end else if (slot_evt) begin
         hdr3_q     <= (fmt_w == FMT_656) & hdr_emit_w & (hidx_w == 2'b11);
         vid656_q   <= (fmt_w == FMT_656) & ~hdr_emit_w & vis_w;
         blank656_q <= (fmt_w == FMT_656) & ~hdr_emit_w & ~vis_w;
         fmt411_q   <= (fmt_w == FMT_411);
         fmt656_q   <= (fmt_w == FMT_656);
         lim_q      <= (fmt_w == FMT_16) & ctrl_reg.code_limit;
      end
   end

   default clocking cb_main @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   AST_SAV_FIRST_ONES: assert property (
      slot_evt && fmt_w == FMT_656 && sav_w && hidx_w == 2'b00 |=> luma_o == 8'hff)
      else $error("SAV first word is not all ones");
   AST_PROTECT_BITS: assert property (
      hdr3_q |-> luma_o[7] && luma_o[3] == (luma_o[5] ^ luma_o[4])
                 && luma_o[2] == (luma_o[6] ^ luma_o[4])
                 && luma_o[1] == (luma_o[6] ^ luma_o[5])
                 && luma_o[0] == (luma_o[6] ^ luma_o[5] ^ luma_o[4]))
      else $error("Header flag word protection bits wrong");
   AST_VIDEO_CLIP: assert property (
      vid656_q |-> luma_o != 8'h00 && luma_o != 8'hff)
      else $error("Reserved code inside 656 video");
   AST_BLANK_WORDS: assert property (
      slot_evt && fmt_w == FMT_656 && !hdr_emit_w && !vis_w
      |=> blank656_q && luma_o == ($past(sub_reg) ? BLANK_Y : BLANK_C))
      else $error("Blanking word value wrong");
   AST_PIN_TRISTATE: assert property (
      $rose(oen_s2_reg) |=> !luma_oe_o && !chroma_oe_o)
      else $error("Data not tristated by output-enable pin");
   AST_SOFT_HIZ: assert property (
      ctrl_reg.data_hiz && ctrl_reg.sync_hiz |=> !luma_oe_o && !chroma_oe_o && !sync_oe_o)
      else $error("Outputs not tristated by control");
   // Chroma enable follows the control word every clock, the tracker only per slot
   AST_656_NO_SYNC: assert property (
      fmt656_q && $past(ctrl_reg.dbl)
      |-> !hsync_o && !vsync_o && !active_video_marker_o && !chroma_oe_o)
      else $error("Syncs or chroma active in 656 mode");
   AST_EAV_LAST_V: assert property (
      slot_evt && fmt_w == FMT_656 && eav_w && hidx_w == 2'b11 && d4.last
      |=> luma_o[5] && luma_o[4])
      else $error("EAV of last line lacks V flag");
   AST_411_PAIRS: assert property (
      fmt411_q |-> chroma_o[7:4] == chroma_o[3:0])
      else $error("4:1:1 chroma bit pairs differ");
   AST_CODE_RANGE: assert property (
      lim_q && $stable(ctrl_reg) |-> luma_o >= 8'h10 && luma_o <= 8'hf0)
      else $error("Luma outside studio range");

endmodule

// >>> tb/video_sink_model.sv
/* Downstream receiver: makes the line-locked word clock, keeps luma words.
   Assumes the port settles well before the falling edge of that clock. */
`timescale 1ns/1ps
module video_sink_model (
   output logic            pixel_clk_o,
   input  wire logic [7:0] luma_i
);
   logic [7:0] words[$];
   // Free-running line-locked clock, 200 ns period
   initial pixel_clk_o = 1'b0;
   always #100 pixel_clk_o = ~pixel_clk_o;
   // Sample mid-slot so the synchroniser delay never matters
   always @(negedge pixel_clk_o) words.push_back(luma_i);
endmodule

// >>> tb/testbench.sv
/* Self-checking bench for the output formatter in 656, 16-bit and 4:1:1 modes.
   Assumes a 40 MHz core clock and the sink model as word receiver. */
`timescale 1ns/1ps
module testbench;
   import vof_pkg::*;
   logic        clk_i = 1'b0, nrst_i = 1'b0, oe_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        pclk, loe, coe, soe, hs, vs, active_video_marker, byp;
   logic [7:0]  addr = 8'h00, luma, lfsr = 8'h48, chr, c0;
   logic [31:0] wdata = 32'h0, rdata;
   video_in_s   vid = '0;
   int          err_count = 0, n_tests = 0, i, j;
   always #12.5 clk_i = ~clk_i;
   video_output_formatter dut (.clk_i(clk_i), .nrst_i(nrst_i), .pixel_clk_i(pclk),
      .pixel_output_enable_n_i(oe_n), .vid_i(vid), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .luma_o(luma), .luma_oe_o(loe), .chroma_o(chr), .chroma_oe_o(coe), .hsync_o(hs),
      .vsync_o(vs), .active_video_marker_o(active_video_marker), .sync_oe_o(soe), .comb_bypass_o(byp));
   video_sink_model sink (.pixel_clk_o(pclk), .luma_i(luma));
   //////////////////////////////////////////////////////////////////////////////
   task close_out;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   function logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function logic [7:0] flag(input logic f, input logic v, input logic h);
      return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction
   // Video words never take the header codes
   function logic [7:0] clip(input logic [7:0] v);
      return (v == 8'hff) ? 8'hfe : (v == 8'h00) ? 8'h01 : v;
   endfunction
   task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a; wr <= w; rd <= !w; wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0; rd <= 1'b0;
      #1;
   endtask
   task pix(input int n);
      repeat (n * 16) @(posedge clk_i);
   endtask
   // One line: blanking, n pixels of window, blanking; kind picks the line type
   task line(input int kind, input int n);
      logic [7:0] y, cb, cr;
      lfsr = nxt(lfsr);
      y = (kind == 0) ? 8'hff : lfsr;
      cb = (kind == 0) ? 8'h00 : ~lfsr;
      cr = lfsr ^ 8'h5a;
      @(posedge clk_i);
      vid.y <= y; vid.cb <= cb; vid.cr <= cr; vid.field <= lfsr[0];
      vid.vblank <= (kind == 2); vid.line_blank <= (kind == 3); vid.last_line <= (kind == 1);
      sink.words.delete();
      pix(12);
      vid.active <= 1'b1;
      pix(n);
      vid.active <= 1'b0;
      pix(12);
      i = -1; j = -1;
      foreach (sink.words[k]) if (i < 0 && sink.words[k] === 8'hff) i = k;
      foreach (sink.words[k]) if (j < 0 && k > i + 3 && sink.words[k] === 8'hff) j = k;
      if (kind == 3) begin
         chk(i, -1);
      end else begin
         chk({sink.words[i+1], sink.words[i+2]}, 16'h0000);
         chk(sink.words[i+3], flag(lfsr[0], kind == 2, 1'b0));
         if (kind != 2) begin
            chk({sink.words[i+4], sink.words[i+5]}, {clip(cb), clip(y)});
            chk({sink.words[i+6], sink.words[i+7]}, {clip(cr), clip(y)});
         end
         chk(j - i, 2 * n + 4);
         chk({sink.words[j+1], sink.words[j+2]}, 16'h0000);
         chk(sink.words[j+3], flag(lfsr[0], kind == 2 || kind == 1, 1'b1));
         chk({sink.words[j+4], sink.words[j+5]}, {BLANK_C, BLANK_Y});
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      rw(1'b0, REG_CTRL, 32'h0);
      chk(rdata, {20'h0, CTRL_RESET});
      rw(1'b1, REG_CTRL, 32'h3);
      rw(1'b0, REG_CTRL, 32'h0);
      chk(rdata, 32'h3);
      rw(1'b0, 8'h10, 32'h0);
      chk(rdata, 32'h0);
      chk(coe, 1'b0);
      for (int k = 0; k < 6; k++) line(k % 4, 8);
      line(1, 720);
      oe_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(loe, 1'b0);
      oe_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(loe, 1'b1);
      // 16-bit: helper luma limited to the studio range, syncs and marker driven
      rw(1'b1, REG_CTRL, {20'h0, CTRL_RESET});
      @(posedge clk_i);
      vid <= '{y: 8'h00, cb: 8'h05, cr: 8'hff, helper_y: 8'hfa, active: 1'b1, hsync: 1'b1,
               vsync: 1'b1, helper_line: 1'b1, default: '0};
      repeat (80) @(posedge clk_i);
      @(negedge pclk);
      c0 = chr;
      @(negedge pclk);
      chk(luma, ITU_Y_MAX);
      chk({hs, vs, active_video_marker, byp, soe, coe, loe}, 7'h7f);
      chk({c0, chr} == {ITU_C_MIN, ITU_C_MAX} || {c0, chr} == {ITU_C_MAX, ITU_C_MIN}, 1);
      // 4:1:1: each pixel carries the next two bits of the group chroma
      rw(1'b1, REG_CTRL, 32'h4);
      @(posedge clk_i);
      vid.cb <= 8'h1b;
      vid.cr <= 8'he4;
      repeat (80) @(posedge clk_i);
      repeat (4) begin
         @(negedge pclk);
         c0 = chr;
         @(negedge pclk);
         chk(chr, (c0 == 8'hcc) ? 8'h33 : c0 + 8'h33);
      end
      rw(1'b1, REG_CTRL, 32'h18);
      repeat (3) @(posedge clk_i);
      chk({loe, coe, soe}, 3'h0);
      close_out;
   end
   // Seven lines and the mode checks take about 400 us; cut a hang well beyond that
   initial begin
      #1ms;
      err_count++;
      close_out;
   end
endmodule
